/* logic/pmic_slave.sv */
/*
 * Register port slave of the power device, with the write FIFO it feeds.
 * Assumes the register file answers rd_data combinationally from rd_index,
 * and that the power pins come from outside the clock domain.
 */
`timescale 1ns/100ps
`default_nettype none
// How it works
// R1: Oversampled edges cover bus rates to 3.4 MHz.
// R2: Sample on clock rise, change on fall.
// R3: Detect start and stop while clock high.
// R4: Only the master makes start and stop.
// R5: Busy from start until the next stop.
// R6: Repeated start restarts address reception.
// R7: Eight bits, MSB first, then ack slot.
// R8: Pull data low through the ninth pulse.
// R9: Master ends reads by not acknowledging.
// R10: Below lockout, never drive the data line.
// R11: First byte: address plus direction bit.
// R12: Answer only to address 0x60.
// R13: Write: register index byte, then data.
// R14: Read needs index write, then repeated start.
// R15: Index advances after every written data byte.
// R16: Reads never advance the index.
// R17: Host avoids access during memory loading.
// R18: Shutdown under lockout or reset low.
// R19: Standby gives full register access.
// R20: Active while any converter is enabled.
// R21: Foreign address: stay released until start.
module pmic_slave (
    input  wire logic        clk,
    input  wire logic        rst,
    pmic_if.dev              bus,
    input  wire logic        supply_above_lockout,
    input  wire logic        external_reset_input_n,
    input  wire logic        otp_load_done,
    input  wire logic        converter_enabled,
    output logic             wr_valid,
    input  wire logic        wr_ready,
    output logic      [7:0]  wr_index,
    output logic      [7:0]  wr_data,
    output logic      [7:0]  rd_index,
    input  wire logic [7:0]  rd_data,
    output pmic_pkg::pwr_e   dev_state,
    output logic             bus_busy
);
    typedef struct packed {
        logic              scl_s1;
        logic              scl_s2;
        logic              scl_q;
        logic              sda_s1;
        logic              sda_s2;
        logic              sda_q;
        logic [1:0]        pwr_s1;
        logic [1:0]        pwr_s2;
        pmic_pkg::pwr_e    pwr;
        pmic_pkg::link_e   link;
        pmic_pkg::phase_e  phase;
        logic [3:0]        cnt;
        logic [7:0]        shift;
        logic [7:0]        index;
        logic              rw;
        logic              nacked;
        logic              drive;
        logic              busy;
        logic              push;
        logic [15:0]       word;
    } slave_s;

    slave_s cur;
    slave_s nxt;
    logic   power_on;
    logic   access_ok;
    logic   scl_rise;
    logic   scl_fall;
    logic   start_seen;
    logic   stop_seen;
    logic   fifo_ready;
    logic [15:0] fifo_out;

    write_fifo #(
        .WIDTH (pmic_pkg::WORD_W),
        .DEPTH (pmic_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rst       (rst),
        .in_valid  (cur.push),
        .in_ready  (fifo_ready),
        .in_data   (cur.word),
        .out_valid (wr_valid),
        .out_ready (wr_ready),
        .out_data  (fifo_out)
    );

    assign wr_index     = fifo_out[15:8];
    assign wr_data      = fifo_out[7:0];
    assign rd_index     = cur.index;
    assign dev_state    = cur.pwr;
    assign bus_busy     = cur.busy;
    assign bus.sda_oe_d = cur.drive;
    assign bus.sda_o_d  = 1'b0;

    always_comb begin
        nxt        = cur;
        nxt.push   = 1'b0;
        nxt.scl_s1 = bus.scl;
        nxt.scl_s2 = cur.scl_s1;
        nxt.scl_q  = cur.scl_s2;
        nxt.sda_s1 = bus.sda;
        nxt.sda_s2 = cur.sda_s1;
        nxt.sda_q  = cur.sda_s2;
        nxt.pwr_s1 = {supply_above_lockout, external_reset_input_n};
        nxt.pwr_s2 = cur.pwr_s1;
        power_on   = &cur.pwr_s2;
        access_ok  = (cur.pwr == pmic_pkg::PWR_STANDBY) ||
                     (cur.pwr == pmic_pkg::PWR_ACTIVE); // R19 R20
        scl_rise   = cur.scl_s2 && !cur.scl_q; // R1
        scl_fall   = !cur.scl_s2 && cur.scl_q;
        start_seen = cur.scl_s2 && cur.scl_q && cur.sda_q && !cur.sda_s2; // R3
        stop_seen  = cur.scl_s2 && cur.scl_q && !cur.sda_q && cur.sda_s2; // R3

        unique case (cur.pwr)
            pmic_pkg::PWR_SHUTDOWN: if (power_on) nxt.pwr = pmic_pkg::PWR_OTP;
            pmic_pkg::PWR_OTP:      if (otp_load_done) nxt.pwr = pmic_pkg::PWR_STANDBY;
            pmic_pkg::PWR_STANDBY:  if (converter_enabled) nxt.pwr = pmic_pkg::PWR_ACTIVE; // R20
            pmic_pkg::PWR_ACTIVE:   if (!converter_enabled) nxt.pwr = pmic_pkg::PWR_STANDBY;
        endcase
        if (!power_on) begin
            nxt.pwr = pmic_pkg::PWR_SHUTDOWN; // R18
        end

        if (start_seen) begin
            // A repeated start lands here too and simply restarts the address.
            nxt.link  = access_ok ? pmic_pkg::L_RX : pmic_pkg::L_IGN; // R6 R17
            nxt.phase = pmic_pkg::PH_ADDR;
            nxt.cnt   = '0;
            nxt.drive = 1'b0;
            nxt.busy  = 1'b1; // R5
        end else if (stop_seen) begin
            nxt.link  = pmic_pkg::L_IDLE;
            nxt.drive = 1'b0;
            nxt.busy  = 1'b0; // R5
        end else begin
            unique case (cur.link)
                pmic_pkg::L_IDLE, pmic_pkg::L_IGN: begin
                    nxt.drive = 1'b0; // R21
                end
                pmic_pkg::L_RX: begin
                    if (scl_rise) begin
                        nxt.shift = {cur.shift[6:0], cur.sda_s2}; // R2 R7
                        nxt.cnt   = cur.cnt + 4'h1;
                    end else if (scl_fall && cur.cnt == pmic_pkg::BYTE_BITS) begin
                        nxt.link  = pmic_pkg::L_ACK;
                        nxt.drive = 1'b1; // R8
                        unique case (cur.phase)
                            pmic_pkg::PH_ADDR: begin
                                nxt.rw    = cur.shift[0]; // R11
                                nxt.phase = pmic_pkg::PH_REG;
                                if (cur.shift[7:1] != pmic_pkg::SLAVE_ADDR) begin // R12
                                    nxt.link  = pmic_pkg::L_IGN; // R21
                                    nxt.drive = 1'b0;
                                end
                            end
                            pmic_pkg::PH_REG: begin
                                nxt.index = cur.shift; // R13
                                nxt.phase = pmic_pkg::PH_DATA;
                            end
                            pmic_pkg::PH_DATA: begin
                                // A full FIFO refuses the byte with a nack.
                                if (fifo_ready) begin
                                    nxt.push  = 1'b1; // R13
                                    nxt.word  = {cur.index, cur.shift};
                                    nxt.index = cur.index + 8'h01; // R15
                                end else begin
                                    nxt.link  = pmic_pkg::L_IGN;
                                    nxt.drive = 1'b0;
                                end
                            end
                        endcase
                    end
                end
                pmic_pkg::L_ACK: begin
                    if (scl_fall) begin
                        nxt.cnt = '0;
                        if (cur.rw == pmic_pkg::DIR_READ) begin
                            nxt.link  = pmic_pkg::L_TX;
                            nxt.shift = rd_data;
                            nxt.drive = !rd_data[7]; // R7
                        end else begin
                            nxt.link  = pmic_pkg::L_RX;
                            nxt.drive = 1'b0; // R8
                        end
                    end
                end
                pmic_pkg::L_TX: begin
                    if (scl_fall) begin
                        nxt.cnt = cur.cnt + 4'h1;
                        if (cur.cnt == pmic_pkg::LAST_TX) begin
                            nxt.link  = pmic_pkg::L_RACK;
                            nxt.drive = 1'b0;
                        end else begin
                            nxt.shift = {cur.shift[6:0], 1'b0};
                            nxt.drive = !cur.shift[6]; // R2
                        end
                    end
                end
                pmic_pkg::L_RACK: begin
                    if (scl_rise) begin
                        nxt.nacked = cur.sda_s2; // R9
                    end else if (scl_fall) begin
                        nxt.cnt = '0;
                        if (cur.nacked) begin
                            nxt.link = pmic_pkg::L_IGN;
                        end else begin
                            // The same register is sent again; the index stays put.
                            nxt.link  = pmic_pkg::L_TX; // R16
                            nxt.shift = rd_data;
                            nxt.drive = !rd_data[7];
                        end
                    end
                end
                default: begin
                    nxt.link  = pmic_pkg::L_IGN;
                    nxt.drive = 1'b0;
                end
            endcase
        end

        if (!access_ok) begin
            nxt.drive = 1'b0; // R10
            if (cur.link != pmic_pkg::L_IDLE) begin
                nxt.link = pmic_pkg::L_IGN;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cur        <= '0;
            cur.scl_s1 <= 1'b1;
            cur.scl_s2 <= 1'b1;
            cur.scl_q  <= 1'b1;
            cur.sda_s1 <= 1'b1;
            cur.sda_s2 <= 1'b1;
            cur.sda_q  <= 1'b1;
            cur.pwr    <= pmic_pkg::PWR_SHUTDOWN;
            cur.link   <= pmic_pkg::L_IDLE;
            cur.phase  <= pmic_pkg::PH_ADDR;
        end else begin
            cur <= nxt;
        end
    end
endmodule
`default_nettype wire

/* shared/pmic_pkg.sv */
/*
 * Constants and state encodings shared by the two-wire register port ends.
 * Assumes both ends run on one 50 MHz system clock.
 */
package pmic_pkg;
    localparam int CLK_HZ         = 50_000_000;
    localparam int HOST_SCL_HZ    = 100_000;
    localparam int QUARTER_CYCLES = CLK_HZ / (4 * HOST_SCL_HZ);

    localparam logic [6:0] SLAVE_ADDR = 7'h60;
    localparam logic       DIR_WRITE  = 1'b0;
    localparam logic       DIR_READ   = 1'b1;
    localparam logic [3:0] BYTE_BITS  = 4'h8;
    localparam logic [3:0] LAST_TX    = 4'h7;
    localparam int         FIFO_DEPTH = 8;
    localparam int         WORD_W     = 16;

    localparam logic [2:0] STEP_START   = 3'h0;
    localparam logic [2:0] STEP_ADDR_W  = 3'h1;
    localparam logic [2:0] STEP_REG     = 3'h2;
    localparam logic [2:0] STEP_DATA    = 3'h3;
    localparam logic [2:0] STEP_RESTART = 3'h3;
    localparam logic [2:0] STEP_ADDR_R  = 3'h4;
    localparam logic [2:0] STEP_READ    = 3'h5;
    localparam logic [2:0] STEP_STOP_W  = 3'h4;
    localparam logic [2:0] STEP_STOP_R  = 3'h6;

    typedef enum logic [3:0] {
        PWR_SHUTDOWN = 4'h1,
        PWR_OTP      = 4'h2,
        PWR_STANDBY  = 4'h4,
        PWR_ACTIVE   = 4'h8
    } pwr_e;

    typedef enum logic [5:0] {
        L_IDLE = 6'h01,
        L_RX   = 6'h02,
        L_ACK  = 6'h04,
        L_TX   = 6'h08,
        L_RACK = 6'h10,
        L_IGN  = 6'h20
    } link_e;

    typedef enum logic [2:0] {
        PH_ADDR = 3'h1,
        PH_REG  = 3'h2,
        PH_DATA = 3'h4
    } phase_e;

    typedef enum logic [3:0] {
        H_IDLE  = 4'h1,
        H_START = 4'h2,
        H_BIT   = 4'h4,
        H_STOP  = 4'h8
    } host_e;
endpackage

/* shared/pmic_if.sv */
/*
 * Two-wire bus between the bus master and the register port slave.
 * Both lines are open drain with pull-ups; the wire levels are resolved here.
 */
`timescale 1ns/100ps
`default_nettype none
interface pmic_if;
    logic scl_o_h;
    logic scl_oe_h;
    logic sda_o_h;
    logic sda_oe_h;
    logic sda_o_d;
    logic sda_oe_d;
    logic scl;
    logic sda;

    // A line is low while any enabled driver pulls it low, else the pull-up wins.
    assign scl = (scl_oe_h && !scl_o_h) ? 1'b0 : 1'b1;
    assign sda = ((sda_oe_h && !sda_o_h) || (sda_oe_d && !sda_o_d)) ? 1'b0 : 1'b1;

    modport host (output scl_o_h, output scl_oe_h, output sda_o_h, output sda_oe_h,
                  input sda);
    modport dev (output sda_o_d, output sda_oe_d, input scl, input sda);
endinterface
`default_nettype wire

/* logic/pmic_host.sv */
/*
 * Bus master end: one register write or one register read per command.
 * Also holds the valid/ready FIFO in which the slave end queues its writes.
 * Assumes the slave never stretches the clock and that the data line comes
 * from a pin outside the clock domain.
 */
`timescale 1ns/100ps
`default_nettype none
module pmic_host #(
    parameter int QUARTER_CYCLES = pmic_pkg::QUARTER_CYCLES
) (
    input  wire logic       clk,
    input  wire logic       rst,
    pmic_if.host            bus,
    input  wire logic       cmd_valid,
    output logic            cmd_ready,
    input  wire logic       cmd_read,
    input  wire logic [7:0] cmd_reg,
    input  wire logic [7:0] cmd_data,
    output logic            rsp_valid,
    output logic            rsp_ack,
    output logic      [7:0] rsp_data
);
    typedef struct packed {
        logic            sda_s1;
        logic            sda_s2;
        pmic_pkg::host_e phase;
        logic [1:0]      q;
        logic [15:0]     tick;
        logic [3:0]      bit_n;
        logic [2:0]      step;
        logic            rd;
        logic [7:0]      reg_i;
        logic [7:0]      data_i;
        logic [7:0]      shift;
        logic            rx;
        logic            acked;
        logic            scl_oe;
        logic            sda_oe;
        logic            cmd_ready;
        logic            rsp_valid;
        logic            rsp_ack;
        logic [7:0]      rsp_data;
    } host_s;

    host_s      cur;
    host_s      nxt;
    logic       qtick;
    logic [2:0] s;

    assign bus.scl_oe_h = cur.scl_oe;
    assign bus.sda_oe_h = cur.sda_oe;
    assign bus.scl_o_h  = 1'b0;
    assign bus.sda_o_h  = 1'b0;
    assign cmd_ready    = cur.cmd_ready;
    assign rsp_valid    = cur.rsp_valid;
    assign rsp_ack      = cur.rsp_ack;
    assign rsp_data     = cur.rsp_data;

    always_comb begin
        nxt           = cur;
        nxt.rsp_valid = 1'b0;
        nxt.sda_s1    = bus.sda;
        nxt.sda_s2    = cur.sda_s1;
        qtick         = (cur.tick == 16'(QUARTER_CYCLES - 1));
        s             = cur.step + 3'h1;
        if (cur.phase != pmic_pkg::H_IDLE) begin
            nxt.tick = qtick ? '0 : cur.tick + 16'h0001;
            if (qtick) nxt.q = cur.q + 2'h1;
        end
        unique case (cur.phase)
            pmic_pkg::H_IDLE: begin
                if (cmd_valid) begin
                    nxt.cmd_ready = 1'b0;
                    nxt.rd        = cmd_read;
                    nxt.reg_i     = cmd_reg;
                    nxt.data_i    = cmd_data;
                    nxt.step      = pmic_pkg::STEP_START;
                    nxt.acked     = 1'b1;
                    nxt.phase     = pmic_pkg::H_START;
                    nxt.q         = '0;
                    nxt.tick      = '0;
                end
            end
            pmic_pkg::H_START: begin
                // Release data before clock so a repeated start is legal too.
                if (qtick) begin
                    unique case (cur.q)
                        2'h0: nxt.sda_oe = 1'b0;
                        2'h1: nxt.scl_oe = 1'b0;
                        2'h2: nxt.sda_oe = 1'b1; // R4 R6
                        2'h3: begin
                            nxt.scl_oe = 1'b1;
                            nxt.phase  = pmic_pkg::H_BIT;
                            nxt.bit_n  = '0;
                            nxt.step   = s;
                            nxt.rx     = 1'b0;
                            nxt.shift  = (s == pmic_pkg::STEP_ADDR_W) ?
                                {pmic_pkg::SLAVE_ADDR, pmic_pkg::DIR_WRITE} :
                                {pmic_pkg::SLAVE_ADDR, pmic_pkg::DIR_READ}; // R11 R14
                        end
                    endcase
                end
            end
            pmic_pkg::H_BIT: begin
                if (qtick) begin
                    unique case (cur.q)
                        2'h0: nxt.sda_oe = (cur.bit_n != pmic_pkg::BYTE_BITS) &&
                                           !cur.rx && !cur.shift[7]; // R2 R7 R9
                        2'h1: nxt.scl_oe = 1'b0;
                        2'h2: begin
                            if (cur.bit_n != pmic_pkg::BYTE_BITS) begin
                                nxt.shift = {cur.shift[6:0], cur.sda_s2};
                            end else if (!cur.rx) begin
                                nxt.acked = cur.acked && !cur.sda_s2; // R8
                            end
                        end
                        2'h3: begin
                            nxt.scl_oe = 1'b1;
                            nxt.bit_n  = cur.bit_n + 4'h1;
                            if (cur.bit_n == pmic_pkg::BYTE_BITS) begin
                                nxt.step  = s;
                                nxt.bit_n = '0;
                                nxt.rx    = cur.rd && (s == pmic_pkg::STEP_READ);
                                if (!nxt.acked || s == (cur.rd ? pmic_pkg::STEP_STOP_R :
                                                               pmic_pkg::STEP_STOP_W)) begin
                                    nxt.phase = pmic_pkg::H_STOP;
                                end else if (cur.rd && s == pmic_pkg::STEP_RESTART) begin
                                    nxt.phase = pmic_pkg::H_START; // R14
                                end else begin
                                    nxt.shift = (s == pmic_pkg::STEP_REG) ? cur.reg_i :
                                                (s == pmic_pkg::STEP_DATA) ? cur.data_i :
                                                8'hff; // R13
                                end
                                if (cur.rx) nxt.rsp_data = cur.shift;
                            end
                        end
                    endcase
                end
            end
            pmic_pkg::H_STOP: begin
                if (qtick) begin
                    unique case (cur.q)
                        2'h0: nxt.sda_oe = 1'b1;
                        2'h1: nxt.scl_oe = 1'b0;
                        2'h2: nxt.sda_oe = 1'b0; // R3 R4
                        2'h3: begin
                            nxt.phase     = pmic_pkg::H_IDLE;
                            nxt.cmd_ready = 1'b1;
                            nxt.rsp_valid = 1'b1;
                            nxt.rsp_ack   = cur.acked;
                        end
                    endcase
                end
            end
            default: nxt.phase = pmic_pkg::H_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cur           <= '0;
            cur.sda_s1    <= 1'b1;
            cur.sda_s2    <= 1'b1;
            cur.phase     <= pmic_pkg::H_IDLE;
            cur.cmd_ready <= 1'b1;
        end else begin
            cur <= nxt;
        end
    end
endmodule

module write_fifo #(
    parameter int WIDTH = pmic_pkg::WORD_W,
    parameter int DEPTH = pmic_pkg::FIFO_DEPTH
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [CW-1:0]               cnt;
    } fifo_s;

    fifo_s cur;
    fifo_s nxt;
    logic  do_in;
    logic  do_out;

    assign in_ready  = (cur.cnt != CW'(DEPTH));
    assign out_valid = (cur.cnt != '0);
    assign out_data  = cur.mem[cur.rp];

    always_comb begin
        nxt    = cur;
        do_in  = in_valid && in_ready;
        do_out = out_valid && out_ready;
        if (do_in) begin
            nxt.mem[cur.wp] = in_data;
            nxt.wp = (cur.wp == AW'(DEPTH - 1)) ? '0 : cur.wp + AW'(1);
        end
        if (do_out) begin
            nxt.rp = (cur.rp == AW'(DEPTH - 1)) ? '0 : cur.rp + AW'(1);
        end
        if (do_in && !do_out) begin
            nxt.cnt = cur.cnt + CW'(1);
        end else if (!do_in && do_out) begin
            nxt.cnt = cur.cnt - CW'(1);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cur <= '0;
        end else begin
            cur <= nxt;
        end
    end
endmodule
`default_nettype wire

/* test/pmic_bus_sva.sv */
/* Concurrent checks on the two-wire link between the host end and the slave end.
   Assumes one shared clock and that frames are counted from each start. */
`timescale 1ns/100ps
`default_nettype none
module pmic_bus_sva (
    input wire logic clk,
    input wire logic rst,
    input wire logic scl_o_h,
    input wire logic scl_oe_h,
    input wire logic sda_o_h,
    input wire logic sda_oe_h,
    input wire logic sda_o_d,
    input wire logic sda_oe_d,
    input wire logic scl,
    input wire logic sda
);
    logic [4:0] bitn_ff;
    logic [7:0] shift_ff;
    logic       busy_ff;
    logic       slot;
    // Acknowledge pulses fall on the 9th, 18th and 27th clock pulses after a start.
    assign slot = (bitn_ff == 5'h8) || (bitn_ff == 5'h11) || (bitn_ff == 5'h1a);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bitn_ff <= 5'h0;
            shift_ff <= 8'h0;
            busy_ff <= 1'b0;
        end else if ($fell(sda) && scl) begin
            bitn_ff <= 5'h0;
            busy_ff <= 1'b1;
        end else if ($rose(sda) && scl) begin
            busy_ff <= 1'b0;
        end else if ($rose(scl)) begin
            bitn_ff <= bitn_ff + 5'h1;
            if (bitn_ff < 5'h8) begin
                shift_ff <= {shift_ff[6:0], sda};
            end
        end
    end
    a_open_drain: assert property (!(scl_o_h || sda_o_h || sda_o_d))
        else $error("a bus line is driven high");
    a_dev_edge_low: assert property ($changed(sda_oe_d) |-> !scl)
        else $error("slave moved data while the clock was high");
    a_dev_slot_only:
        assert property ($rose(scl) && sda_oe_d |-> slot
            || (shift_ff[0] && bitn_ff > 5'h8 && bitn_ff < 5'h11))
        else $error("slave drove data outside its slots");
    a_host_ack_free: assert property ($rose(scl) && slot |-> !sda_oe_h)
        else $error("master held data in an acknowledge pulse");
    a_foreign_silent:
        assert property ($rose(scl) && bitn_ff > 5'h7
            && shift_ff[7:1] != pmic_pkg::SLAVE_ADDR |-> !sda_oe_d)
        else $error("slave answered a foreign address");
    a_idle_high: assert property (!busy_ff |-> scl)
        else $error("clock low while the bus is free");
    a_start_low: assert property ($fell(sda) && scl |-> ##[1:600] !scl)
        else $error("no clock pulse after a start");
    a_stop_idle: assert property ($rose(sda) && scl |-> scl [*8])
        else $error("clock moved right after a stop");
endmodule
`default_nettype wire

/* test/testbench.sv */
/* Self-checking bench: the host end talks to the slave end over the shared bus.
   Assumes a 50 MHz clock; a quarter count of 8 keeps every frame short. */
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic clk, rst, cmd_valid, cmd_ready, cmd_read, rsp_valid, rsp_ack;
    logic [7:0] cmd_reg, cmd_data, rsp_data, wr_index, wr_data, rd_index, k;
    logic supply_above_lockout, external_reset_input_n, otp_load_done;
    logic converter_enabled, wr_valid, wr_ready, bus_busy;
    logic [7:0] mem [256];
    pmic_pkg::pwr_e dev_state;
    int failures, check_count;
    pmic_if bus ();
    pmic_host #(.QUARTER_CYCLES(8)) i_pmic_host (.clk, .rst, .bus(bus.host), .cmd_valid,
        .cmd_ready, .cmd_read, .cmd_reg, .cmd_data, .rsp_valid, .rsp_ack, .rsp_data);
    pmic_slave i_pmic_slave (.clk, .rst, .bus(bus.dev), .supply_above_lockout,
        .external_reset_input_n, .otp_load_done, .converter_enabled, .wr_valid, .wr_ready,
        .wr_index, .wr_data, .rd_index, .rd_data(mem[rd_index]), .dev_state, .bus_busy);
    pmic_bus_sva i_pmic_bus_sva (.clk, .rst, .scl_o_h(bus.scl_o_h), .scl_oe_h(bus.scl_oe_h),
        .sda_o_h(bus.sda_o_h), .sda_oe_h(bus.sda_oe_h), .sda_o_d(bus.sda_o_d),
        .sda_oe_d(bus.sda_oe_d), .scl(bus.scl), .sda(bus.sda));
    // Register file stand-in: stores each byte the slave hands out.
    always_ff @(posedge clk) begin
        if (wr_valid && wr_ready) begin
            mem[wr_index] <= wr_data;
        end
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic st(input pmic_pkg::pwr_e e);
        check({4'h0, dev_state}, {4'h0, e});
    endtask
    task automatic xfer(input logic rd, input logic [7:0] r, input logic [7:0] d,
                        input logic ack, input logic [7:0] q);
        int n;
        cmd_read = rd;
        cmd_reg = r;
        cmd_data = d;
        cmd_valid = 1'b1;
        @(negedge clk);
        cmd_valid = 1'b0;
        n = 0;
        // A read frame runs about 1250 clocks at a quarter count of 8.
        while (rsp_valid !== 1'b1 && n < 2000) begin
            @(negedge clk);
            n++;
            if (n == 100) check({7'h0, bus_busy}, 8'h1);
        end
        if (n >= 2000) failures++;
        check({7'h0, rsp_ack}, {7'h0, ack});
        if (rd && ack) begin
            check(rsp_data, q);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Frames take up to about 1250 cycles each; the limit leaves a third spare.
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        wrap_up();
    end
    initial begin
        {rst, cmd_valid, cmd_read, cmd_reg, cmd_data} = {1'b1, 1'b0, 1'b0, 8'h0, 8'h0};
        {supply_above_lockout, external_reset_input_n} = 2'b00;
        {otp_load_done, converter_enabled, wr_ready} = 3'b000;
        repeat (16) @(negedge clk);
        rst = 1'b0;
        st(pmic_pkg::PWR_SHUTDOWN);
        xfer(1'b0, 8'h01, 8'h55, 1'b0, 8'h0);
        {supply_above_lockout, external_reset_input_n} = 2'b11;
        repeat (6) @(negedge clk);
        st(pmic_pkg::PWR_OTP);
        otp_load_done = 1'b1;
        repeat (3) @(negedge clk);
        st(pmic_pkg::PWR_STANDBY);
        for (k = 8'h0; k < 8'h8; k++) begin
            xfer(1'b0, 8'h10 + k, 8'ha0 + k, 1'b1, 8'h0);
        end
        // The ninth byte meets a full buffer and must be refused.
        xfer(1'b0, 8'h18, 8'ha8, 1'b0, 8'h0);
        check({7'h0, bus_busy}, 8'h0);
        wr_ready = 1'b1;
        for (k = 8'h0; k < 8'h8; k++) begin
            check({wr_valid, wr_index[6:0]}, 8'h90 + k);
            check(wr_data, 8'ha0 + k);
            @(negedge clk);
        end
        check({7'h0, wr_valid}, 8'h0);
        xfer(1'b1, 8'h12, 8'h00, 1'b1, 8'ha2);
        xfer(1'b1, 8'h17, 8'h00, 1'b1, 8'ha7);
        check(rd_index, 8'h17);
        converter_enabled = 1'b1;
        repeat (3) @(negedge clk);
        st(pmic_pkg::PWR_ACTIVE);
        xfer(1'b0, 8'h30, 8'h5c, 1'b1, 8'h0);
        check(rd_index, 8'h31);
        xfer(1'b1, 8'h30, 8'h00, 1'b1, 8'h5c);
        supply_above_lockout = 1'b0;
        repeat (4) @(negedge clk);
        st(pmic_pkg::PWR_SHUTDOWN);
        xfer(1'b0, 8'h31, 8'h66, 1'b0, 8'h0);
        wrap_up();
    end
endmodule
`default_nettype wire
